/* File: inc/tbp_params.svh */
`ifndef TBP_PARAMS_SVH
`define TBP_PARAMS_SVH

// register byte offsets
`define TBP_OFS_COUNT 8'h00
`define TBP_OFS_PERIOD 8'h04
`define TBP_OFS_TCON 8'h08
`define TBP_OFS_FLAG 8'h0c
`define TBP_OFS_DIR 8'h10
`define TBP_CH_BASE 8'h20
`define TBP_CH_STRIDE 8'h10
`define TBP_OFS_CTL 8'h00
`define TBP_OFS_DCH 8'h04
`define TBP_OFS_DCL 8'h08

// field positions
`define TBP_CTL_EN 7
`define TBP_CTL_OUT 5
`define TBP_CTL_POL 4
`define TBP_DCL_MSB 7
`define TBP_DCL_LSB 6
`define TBP_TCON_ON 7
`define TBP_TCON_PS_MSB 6
`define TBP_TCON_PS_LSB 4
`define TBP_TCON_POST_MSB 3
`define TBP_FLG_MATCH 1

// reset values and counts
`define TBP_PERIOD_RST 8'hff
`define TBP_BYTE_RST 8'h00
`define TBP_SUB_LAST 2'h3
`define TBP_NCH_MAX 4

`endif

/* File: inc/tbp_pkg.sv */
package tbp_pkg;
  typedef logic [7:0] tbp_byte_t;
  typedef logic [9:0] tbp_duty_t;
  typedef logic [1:0] tbp_sub_t;
endpackage

/* File: inc/tbp_chan_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tbp_chan_if;
  logic wrap;
  tbp_pkg::tbp_duty_t time_base;
  tbp_pkg::tbp_byte_t period;
  logic wr_ctl;
  logic wr_dch;
  logic wr_dcl;
  tbp_pkg::tbp_byte_t wdata;
  tbp_pkg::tbp_byte_t ctl_rd;
  tbp_pkg::tbp_byte_t dch_rd;
  tbp_pkg::tbp_byte_t dcl_rd;
  logic level;
  modport top (output wrap, time_base, period, wr_ctl, wr_dch, wr_dcl, wdata,
               input ctl_rd, dch_rd, dcl_rd, level);
  modport chan (input wrap, time_base, period, wr_ctl, wr_dch, wr_dcl, wdata,
                output ctl_rd, dch_rd, dcl_rd, level);
endinterface
`default_nettype wire

/* File: core/tbp_channel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tbp_params.svh"
module tbp_channel (
  input wire logic hclk,
  input wire logic hresetn,
  tbp_chan_if.chan ci
);

  logic en_ff, nxt_en;
  logic pol_ff, nxt_pol;
  tbp_pkg::tbp_byte_t dch_ff, nxt_dch;
  tbp_pkg::tbp_sub_t dcl_ff, nxt_dcl;
  tbp_pkg::tbp_duty_t buf_ff, nxt_buf;
  logic wave_ff, nxt_wave;
  logic out_ff, nxt_out;
  tbp_pkg::tbp_duty_t duty_reg;
  tbp_pkg::tbp_duty_t tb_last;

  assign duty_reg = {dch_ff, dcl_ff};
  assign tb_last = {ci.period, `TBP_SUB_LAST};

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_en = en_ff;
    nxt_pol = pol_ff;
    nxt_dch = dch_ff;
    nxt_dcl = dcl_ff;
    if (ci.wr_ctl) begin
      nxt_en = ci.wdata[`TBP_CTL_EN];
      nxt_pol = ci.wdata[`TBP_CTL_POL];
    end
    // writes land in the software copy only
    if (ci.wr_dch) begin
      nxt_dch = ci.wdata;
    end
    if (ci.wr_dcl) begin
      nxt_dcl = ci.wdata[`TBP_DCL_MSB:`TBP_DCL_LSB];
    end
    nxt_buf = ci.wrap ? duty_reg : buf_ff;
    if (!en_ff) begin
      nxt_wave = 1'b0;
    end else if (ci.wrap) begin
      nxt_wave = (duty_reg != 10'h000);
    end else if (ci.time_base == buf_ff) begin
      nxt_wave = 1'b0;
    end else begin
      nxt_wave = wave_ff;
    end
    nxt_out = nxt_wave ^ nxt_pol;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_ff <= 1'b0;
      pol_ff <= 1'b0;
      dch_ff <= `TBP_BYTE_RST;
      dcl_ff <= 2'h0;
      buf_ff <= 10'h000;
      wave_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      en_ff <= nxt_en;
      pol_ff <= nxt_pol;
      dch_ff <= nxt_dch;
      dcl_ff <= nxt_dcl;
      buf_ff <= nxt_buf;
      wave_ff <= nxt_wave;
      out_ff <= nxt_out;
    end
  end

  assign ci.level = out_ff;
  assign ci.ctl_rd = {en_ff, 1'b0, out_ff, pol_ff, 4'h0};
  assign ci.dch_rd = dch_ff;
  assign ci.dcl_rd = {dcl_ff, 6'h00};

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  period_set_a: assert property (ci.wrap && en_ff && duty_reg != 10'h000 |=> wave_ff)
    else $error("output not active at period start");
  zero_duty_a: assert property (ci.wrap && duty_reg == 10'h000 |=> !wave_ff)
    else $error("zero duty drove output active");
  match_clear_a: assert property (!ci.wrap && ci.time_base == buf_ff |=> !wave_ff)
    else $error("output not cleared on duty match");
  full_duty_a: assert property (en_ff && wave_ff && !ci.wrap && buf_ff > tb_last
    && ci.time_base <= tb_last |=> wave_ff)
    else $error("full duty output cleared");
  buffer_hold_a: assert property (!ci.wrap |=> buf_ff == $past(buf_ff))
    else $error("duty buffer changed off period boundary");
  buffer_load_a: assert property (ci.wrap |=> buf_ff == $past(duty_reg))
    else $error("duty buffer not loaded at wrap");
  out_polarity_a: assert property (out_ff == (wave_ff ^ pol_ff))
    else $error("output polarity mismatch");
  disabled_low_a: assert property (!en_ff |=> !wave_ff)
    else $error("disabled channel waveform active");

  full_duty_c: cover property (en_ff && ci.wrap && duty_reg > {ci.period, `TBP_SUB_LAST});
  mid_clear_c: cover property (en_ff && wave_ff ##1 !wave_ff);
endmodule
`default_nettype wire

/* File: core/tbp_pwm_top.sv */
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tbp_params.svh"
// Function
// - each enabled channel with non-zero duty goes active when the shared count clears at period start
// - channel goes inactive when 10-bit time base equals its buffered duty
// - duty beyond the period end never clears, giving full duty
// - duty registers double-buffered, loaded only at the period match
// - duty writes allowed anytime, never disturbing the running period
// - after count equals period: clear count, load buffers, go active unless zero
// - period is (period value + 1) x 4 x prescale clocks
// - duty is high byte plus bits 7:6 of the low register
// - time base is count plus 2-bit sub-count; 1:1 prescale steps each clock
// - postscaler only shapes the match flag, never the waveform
// - all channels share one count and period, each has its own duty
// - resolution is log2 of 4 x (period + 1), ten bits at 255
// - sleep freezes count and all state; resumes from held count
// - reset restores register defaults and returns pins to input
// - polarity select set inverts the channel output
// - control bit 7 enables the channel
// - control bit 5 reads back the current output level
// - control bit 4 set gives active-low output
module tbp_pwm_top #(
  parameter int NCH = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sleep_req,
  output logic [NCH-1:0] pwm_out,
  output logic [NCH-1:0] pin_oe
);

  generate
    if (NCH < 1 || NCH > `TBP_NCH_MAX) begin : g_chk
      $error("NCH out of range");
    end
  endgenerate

  function automatic logic [7:0] chan_addr(input int ch, input logic [7:0] ofs);
    chan_addr = `TBP_CH_BASE + 8'(ch) * `TBP_CH_STRIDE + ofs;
  endfunction

  function automatic logic [6:0] presc_last(input logic [2:0] sel);
    presc_last = 7'((8'h01 << sel) - 8'h01);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: writes zero-wait, reads one wait state
  logic addr_take;
  logic wr_pend_ff, nxt_wr_pend;
  logic rd_pend_ff, nxt_rd_pend;
  logic [7:0] addr_ff, nxt_addr;
  logic ready_ff, nxt_ready;
  logic [31:0] rdata_ff, nxt_rdata;
  tbp_pkg::tbp_byte_t rd_mux;
  tbp_pkg::tbp_byte_t wbyte;
  logic wr_count, wr_period, wr_tcon, wr_flag, wr_dir;

  assign addr_take = hsel && htrans[1] && hready;
  assign wbyte = hwdata[7:0];
  assign wr_count = wr_pend_ff && addr_ff == `TBP_OFS_COUNT;
  assign wr_period = wr_pend_ff && addr_ff == `TBP_OFS_PERIOD;
  assign wr_tcon = wr_pend_ff && addr_ff == `TBP_OFS_TCON;
  assign wr_flag = wr_pend_ff && addr_ff == `TBP_OFS_FLAG;
  assign wr_dir = wr_pend_ff && addr_ff == `TBP_OFS_DIR;

  always_comb begin
    nxt_wr_pend = addr_take && hwrite;
    nxt_rd_pend = addr_take && !hwrite;
    nxt_addr = addr_take ? haddr[7:0] : addr_ff;
    nxt_ready = !(addr_take && !hwrite);
    nxt_rdata = rd_pend_ff ? {24'h000000, rd_mux} : rdata_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
      ready_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      rd_pend_ff <= nxt_rd_pend;
      addr_ff <= nxt_addr;
      ready_ff <= nxt_ready;
      rdata_ff <= nxt_rdata;
    end
  end

  assign hrdata = rdata_ff;
  assign hreadyout = ready_ff;
  assign hresp = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // sleep request from outside the clock domain
  logic slp_s1_ff, slp_s2_ff, slp_s3_ff;
  logic sleep_ff, nxt_sleep;

  always_comb begin
    nxt_sleep = (slp_s2_ff == slp_s3_ff) ? slp_s3_ff : sleep_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slp_s1_ff <= 1'b0;
      slp_s2_ff <= 1'b0;
      slp_s3_ff <= 1'b0;
      sleep_ff <= 1'b0;
    end else begin
      slp_s1_ff <= sleep_req;
      slp_s2_ff <= slp_s1_ff;
      slp_s3_ff <= slp_s2_ff;
      sleep_ff <= nxt_sleep;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software registers of the shared timer and pins
  tbp_pkg::tbp_byte_t period_ff, nxt_period;
  tbp_pkg::tbp_byte_t tcon_ff, nxt_tcon;
  logic flag_ff, nxt_flag;
  logic [3:0] post_ff, nxt_post;
  logic [NCH-1:0] drv_ff, nxt_drv;
  logic wrap;

  always_comb begin
    nxt_period = wr_period ? wbyte : period_ff;
    nxt_tcon = wr_tcon ? wbyte : tcon_ff;
    nxt_drv = wr_dir ? ~wbyte[NCH-1:0] : drv_ff;
    nxt_post = post_ff;
    nxt_flag = flag_ff;
    if (wr_flag && wbyte[`TBP_FLG_MATCH]) begin
      nxt_flag = 1'b0;
    end
    // postscaler gates only the flag; a set beats a same-cycle clear
    if (wrap) begin
      if (post_ff == tcon_ff[`TBP_TCON_POST_MSB:0]) begin
        nxt_post = 4'h0;
        nxt_flag = 1'b1;
      end else begin
        nxt_post = post_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_ff <= `TBP_PERIOD_RST;
      tcon_ff <= `TBP_BYTE_RST;
      flag_ff <= 1'b0;
      post_ff <= 4'h0;
      drv_ff <= '0;
    end else begin
      period_ff <= nxt_period;
      tcon_ff <= nxt_tcon;
      flag_ff <= nxt_flag;
      post_ff <= nxt_post;
      drv_ff <= nxt_drv;
    end
  end

  assign pin_oe = drv_ff;

  //////////////////////////////////////////////////////////////////////////////
  // shared time base: prescaler, 2-bit sub-count, 8-bit count
  logic [6:0] pre_ff, nxt_pre;
  tbp_pkg::tbp_sub_t sub_ff, nxt_sub;
  tbp_pkg::tbp_byte_t count_ff, nxt_count;
  logic run, tick;

  assign run = tcon_ff[`TBP_TCON_ON] && !sleep_ff;
  // at or past the last step, so a prescale cut mid-count never waits for a 7-bit wrap
  assign tick = run && pre_ff >= presc_last(tcon_ff[`TBP_TCON_PS_MSB:`TBP_TCON_PS_LSB]);
  assign wrap = tick && sub_ff == `TBP_SUB_LAST && count_ff == period_ff;

  always_comb begin
    nxt_pre = pre_ff;
    nxt_sub = sub_ff;
    nxt_count = count_ff;
    if (tick) begin
      nxt_pre = 7'h00;
      nxt_sub = sub_ff + 2'h1;
      if (sub_ff == `TBP_SUB_LAST) begin
        nxt_count = (count_ff == period_ff) ? 8'h00 : count_ff + 8'h01;
      end
    end else if (run) begin
      nxt_pre = pre_ff + 7'h01;
    end
    if (wr_count) begin
      nxt_count = wbyte;
      nxt_pre = 7'h00;
      nxt_sub = 2'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_ff <= 7'h00;
      sub_ff <= 2'h0;
      count_ff <= `TBP_BYTE_RST;
    end else begin
      pre_ff <= nxt_pre;
      sub_ff <= nxt_sub;
      count_ff <= nxt_count;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channels share wrap and time base
  tbp_pkg::tbp_byte_t ctl_rd [NCH];
  tbp_pkg::tbp_byte_t dch_rd [NCH];
  tbp_pkg::tbp_byte_t dcl_rd [NCH];

  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      tbp_chan_if ci ();
      assign ci.wrap = wrap;
      assign ci.time_base = {count_ff, sub_ff};
      assign ci.period = period_ff;
      assign ci.wr_ctl = wr_pend_ff && addr_ff == chan_addr(i, `TBP_OFS_CTL);
      assign ci.wr_dch = wr_pend_ff && addr_ff == chan_addr(i, `TBP_OFS_DCH);
      assign ci.wr_dcl = wr_pend_ff && addr_ff == chan_addr(i, `TBP_OFS_DCL);
      assign ci.wdata = wbyte;
      assign ctl_rd[i] = ci.ctl_rd;
      assign dch_rd[i] = ci.dch_rd;
      assign dcl_rd[i] = ci.dcl_rd;
      assign pwm_out[i] = ci.level;
      tbp_channel u_ch (
        .hclk(hclk),
        .hresetn(hresetn),
        .ci(ci)
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read decode; unmapped reads return zero
  always_comb begin
    rd_mux = 8'h00;
    case (addr_ff)
      `TBP_OFS_COUNT: begin
        rd_mux = count_ff;
      end
      `TBP_OFS_PERIOD: begin
        rd_mux = period_ff;
      end
      `TBP_OFS_TCON: begin
        rd_mux = tcon_ff;
      end
      `TBP_OFS_FLAG: begin
        rd_mux[`TBP_FLG_MATCH] = flag_ff;
      end
      `TBP_OFS_DIR: begin
        rd_mux[NCH-1:0] = ~drv_ff;
      end
      default: begin
      end
    endcase
    for (int i = 0; i < NCH; i++) begin
      if (addr_ff == chan_addr(i, `TBP_OFS_CTL)) begin
        rd_mux = ctl_rd[i];
      end
      if (addr_ff == chan_addr(i, `TBP_OFS_DCH)) begin
        rd_mux = dch_rd[i];
      end
      if (addr_ff == chan_addr(i, `TBP_OFS_DCL)) begin
        rd_mux = dcl_rd[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  count_wrap_a: assert property (wrap && !wr_count |=> count_ff == 8'h00 && sub_ff == 2'h0)
    else $error("count not cleared after period match");
  count_step_a: assert property (tick && sub_ff == `TBP_SUB_LAST && count_ff != period_ff
    && !wr_count |=> count_ff == $past(count_ff) + 8'h01)
    else $error("count did not advance after four sub steps");
  presc_one_a: assert property (run && tcon_ff[`TBP_TCON_PS_MSB:`TBP_TCON_PS_LSB] == 3'h0 |-> tick)
    else $error("1:1 prescale missed a clock");
  sleep_hold_a: assert property (sleep_ff && !wr_count |=> $stable(count_ff) && $stable(sub_ff))
    else $error("time base moved in sleep");
  read_wait_a: assert property (addr_take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");

  wrap_c: cover property (wrap);
  sleep_c: cover property (sleep_ff && tcon_ff[`TBP_TCON_ON]);
  flag_c: cover property (wrap && tcon_ff[`TBP_TCON_POST_MSB:0] != 4'h0 ##1 flag_ff);
endmodule
`default_nettype wire

/* File: testbench/tbp_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tbp_pin_model #(
  parameter int NCH = 2
) (
  input wire logic [NCH-1:0] pwm_out,
  input wire logic [NCH-1:0] pin_oe,
  output logic [NCH-1:0] pin_lvl
);
  // a pin left as input floats up to its pull-up, never to the last pwm level
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pin_lvl[i] = pin_oe[i] ? pwm_out[i] : 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tbp_params.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  $display("Error %s expected %0h seen %0h", nm, ex, got); n_fail++; end end
module tb;
  logic hclk, hresetn, hsel, hwrite, sleep_req, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, pwm_out, pin_oe, pin_lvl;
  logic [2:0] hsize;
  logic [7:0] d, c1;
  wire logic hready;
  int n_fail, compares, hi, ri, k;
  assign hready = hreadyout;

  tbp_pwm_top #(.NCH(2)) u_tbp_pwm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sleep_req(sleep_req), .pwm_out(pwm_out), .pin_oe(pin_oe));
  tbp_pin_model #(.NCH(2)) u_tbp_pin_model (.pwm_out(pwm_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wait_rdy;
    int j;
    j = 0;
    do begin
      @(posedge hclk);
      j++;
    end while (hreadyout !== 1'b1 && j < 20);
    if (hreadyout !== 1'b1) begin
      $display("Error bus wait timed out");
      n_fail++;
      test_done;
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    wait_rdy;
    rd = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    logic [7:0] x;
    bus(1'b1, a, wd, x);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00, d);
  endtask

  // samples n cycles of one pin; counts high cycles and rising edges
  task automatic meas(input int ch, input int n);
    logic p;
    hi = 0;
    ri = 0;
    @(posedge hclk);
    p = pin_lvl[ch];
    repeat (n) begin
      @(posedge hclk);
      if (pin_lvl[ch] === 1'b1) hi++;
      if (p === 1'b0 && pin_lvl[ch] === 1'b1) ri++;
      p = pin_lvl[ch];
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  initial begin
    n_fail = 0;
    compares = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    sleep_req = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    `CHK("pin_oe", 2'h0, pin_oe);
    rd(`TBP_OFS_PERIOD); `CHK("period", 8'hff, d);
    rd(`TBP_OFS_DIR); `CHK("dir", 2'h3, d[1:0]);
    rd(8'h20); `CHK("ctl0", 8'h00, d);
    rd(8'h14); `CHK("unmapped", 8'h00, d);
    `CHK("hresp", 1'b0, hresp);
    // setup order for pin use
    wr(`TBP_OFS_DIR, 8'hff);
    wr(8'h20, 8'h00);
    wr(8'h30, 8'h00);
    wr(`TBP_OFS_PERIOD, 8'h01);
    wr(8'h24, 8'h00);
    wr(8'h28, 8'h80);
    wr(8'h34, 8'h00);
    wr(8'h38, 8'h00);
    wr(`TBP_OFS_FLAG, 8'h02);
    wr(`TBP_OFS_TCON, 8'h80);
    k = 0;
    do begin
      rd(`TBP_OFS_FLAG);
      k++;
    end while (d[1] !== 1'b1 && k < 40);
    `CHK("match flag", 1'b1, d[1]);
    if (d[1] !== 1'b1) test_done;
    wr(`TBP_OFS_DIR, 8'hfc);
    @(posedge hclk);
    `CHK("pin_oe", 2'h3, pin_oe);
    wr(8'h20, 8'h80);
    wr(8'h30, 8'h80);
    repeat (16) @(posedge hclk);
    // period 1 gives a 3-bit time base of 8 clocks; duty 2 stays high 3 clocks
    meas(0, 8); `CHK("ch0 high", 3, hi);
    meas(1, 8); `CHK("ch1 zero", 0, hi);
    rd(8'h30); `CHK("ctl1 out low", 8'h80, d);
    wr(8'h24, 8'h01);
    wr(8'h2c - 8'h04, 8'h7f);
    rd(8'h28); `CHK("dcl0", 8'h40, d);
    rd(8'h24); `CHK("dch0", 8'h01, d);
    repeat (16) @(posedge hclk);
    meas(0, 8); `CHK("ch0 duty5", 6, hi);
    meas(1, 8); `CHK("ch1 own duty", 0, hi);
    wr(8'h34, 8'hff);
    wr(8'h38, 8'hc0);
    repeat (16) @(posedge hclk);
    meas(1, 8); `CHK("ch1 full", 8, hi);
    rd(8'h30); `CHK("ctl1 out high", 8'ha0, d);
    wr(8'h20, 8'h90);
    meas(0, 8); `CHK("ch0 inverted", 2, hi);
    wr(8'h20, 8'h10);
    meas(0, 8); `CHK("off inverted", 8, hi);
    wr(8'h20, 8'h00);
    meas(0, 8); `CHK("off plain", 0, hi);
    wr(8'h20, 8'h80);
    // prescale 1:2 doubles the period to 16; postscale must not matter
    wr(`TBP_OFS_TCON, 8'h9f);
    repeat (40) @(posedge hclk);
    meas(0, 32); `CHK("rises ps2", 2, ri);
    wr(`TBP_OFS_TCON, 8'h90);
    repeat (20) @(posedge hclk);
    meas(0, 32); `CHK("rises post0", 2, ri);
    sleep_req <= 1'b1;
    repeat (8) @(posedge hclk);
    rd(`TBP_OFS_COUNT);
    c1 = d;
    meas(0, 20); `CHK("sleep rises", 0, ri);
    `CHK("sleep level", 0, hi % 20);
    rd(`TBP_OFS_COUNT); `CHK("sleep count", c1, d);
    sleep_req <= 1'b0;
    repeat (40) @(posedge hclk);
    meas(0, 32); `CHK("wake rises", 2, ri);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK("rst pin_oe", 2'h0, pin_oe);
    `CHK("rst pwm", 2'h0, pwm_out);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`TBP_OFS_PERIOD); `CHK("rst period", 8'hff, d);
    rd(8'h24); `CHK("rst dch0", 8'h00, d);
    test_done;
  end
endmodule
`default_nettype wire
